// ===== src/oss_clock_select.sv
// Oscillator source selection, clock switching, fail-safe monitor and PLL.
// Assumes configuration word 2 is stable from reset release; oscillator
// pins are asynchronous and pass two flip-flops before use.
//
// Behaviour
// - System clock comes from exactly one of four oscillator sources.
// - Fast RC runs at 8 MHz, optionally lowered by a postscaler.
// - Instruction clock is the selected processor clock divided by two.
// - Oscillator output pin may carry instruction clock, per config bit, in EC or primary-off mode only.
// - Mode field bits 1:0 and source field bits 10:8 pick reset source.
// - Unprogrammed word selects fast RC with postscaler, codes 11 and 111.
// - Clock switching allowed only when switch permit bit is zero.
// - Fail-safe monitor active only when both monitor bits are zero.
// - Source 110 is fast RC / 16, 101 low-power RC, 100 secondary.
// - Source 011 is primary through PLL, 010 primary direct.
// - Source 001 is fast RC through PLL, 000 fast RC direct.
// - Primary and fast RC may feed PLL for USB, graphics, system.
// - USB branch is 20 MHz (40 MHz clock / 2) from PLL while a PLL source is selected and locked; no external USB clock.
`timescale 1ns/10ps
module oss_clock_select
#(
   parameter int unsigned LOW_POWER_RC_OSC_DIV    = 1280,
   parameter int unsigned PLL_SYS_DIV = 3,
   parameter int unsigned FAILSAFE_CLOCK_MONITOR_CYC    = 2048
)
(
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // Configuration word 2
   input  wire logic [15:0]      cfg_word2,
   // Oscillator pins
   input  wire logic             pri_osc_pin,
   input  wire logic             sec_osc_pin,
   // Register port
   input  wire oss_pkg::oss_bus_s bus,
   output logic [15:0]           rdata,
   // Clock enables and instruction clock
   output logic                  sys_clk_en,
   output logic                  instr_clk_en,
   output logic                  instr_clk,
   output logic                  usb_clk_en,
   output logic                  gfx_clk_en,
   // Status
   output logic                  pll_active,
   output logic                  failsafe_clock_monitor_fail,
   // Oscillator output pin
   output logic                  osc_out_pin_o,
   output logic                  osc_out_pin_oe_n
);
   import oss_pkg::*;

   typedef enum logic [1:0] {ST_WAIT_CFG, ST_RUN, ST_SWITCH} oss_state_e;

   oss_state_e  state_q;
   oss_cfg_s    cfg_q;
   logic [2:0]  cur_src_q;
   logic [2:0]  tgt_src_q;
   logic [2:0]  rc_q;
   logic [2:0]  plldiv_q;
   logic        fail_q;
   logic        pll_ok_q;
   logic [7:0]  per_q;
   logic [15:0] wd_q;
   logic        instr_q;
   logic        oe_n_q;
   logic [15:0] rdata_q;
   logic [2:0]  pri_sync_q;
   logic [2:0]  sec_sync_q;

   // Pin synchronisers; stage 2 holds the previous level for edge finding
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pri_sync_q <= 3'h0;
         sec_sync_q <= 3'h0;
      end
      else
      begin
         pri_sync_q <= {pri_sync_q[1:0], pri_osc_pin};
         sec_sync_q <= {sec_sync_q[1:0], sec_osc_pin};
      end
   end

   // Source ticks
   wire running   = (state_q != ST_WAIT_CFG);
   wire pri_on    = (cfg_q.mode != MODE_OFF);
   wire pri_tick  = pri_on && pri_sync_q[1] && !pri_sync_q[2];
   wire sec_tick  = sec_sync_q[1] && !sec_sync_q[2];
   wire [15:0] ps_div = DIV_ONE << rc_q;
   wire frc_tick;
   wire frc_ps_tick;
   wire frc16_tick;
   wire low_power_rc_osc_tick;
   wire pll_in_tick;
   wire pll_sys_tick;
   wire usb_tick;

   // Fast RC base and its derived rates; low-power RC base
   oss_tick_div u_frc (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .tick_in  (1'b1),
      .div      (FRC_DIV),
      .tick_out (frc_tick)
   );
   oss_tick_div u_frc_ps (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .tick_in  (frc_tick),
      .div      (ps_div),
      .tick_out (frc_ps_tick)
   );
   oss_tick_div u_frc16 (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .tick_in  (frc_tick),
      .div      (FRC16_DIV),
      .tick_out (frc16_tick)
   );
   oss_tick_div u_low_power_rc_osc (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .tick_in  (1'b1),
      .div      (16'(LOW_POWER_RC_OSC_DIV)),
      .tick_out (low_power_rc_osc_tick)
   );

   // PLL path follows the target while a switch is in progress
   wire [2:0] path_src = (state_q == ST_SWITCH) ? tgt_src_q : cur_src_q;
   wire pll_want = running && ((path_src == SRC_PRIPLL) || (path_src == SRC_FAST_RC_WITH_PLL));
   wire pll_src_tick = (path_src == SRC_FAST_RC_WITH_PLL) ? frc_ps_tick : pri_tick;

   oss_tick_div u_plldiv (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .tick_in  (pll_src_tick),
      .div      (oss_pll_div(plldiv_q)),
      .tick_out (pll_in_tick)
   );
   oss_tick_div u_pllsys (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .tick_in  (pll_ok_q),
      .div      (16'(PLL_SYS_DIV)),
      .tick_out (pll_sys_tick)
   );
   oss_tick_div u_usb (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .tick_in  (pll_ok_q),
      .div      (USB_DIV),
      .tick_out (usb_tick)
   );

   // PLL input lock check: the divided input must arrive at 4 MHz
   wire per_ok = (per_q >= 8'(PLL_IN_CYC - 1 - PLL_TOL))
              && (per_q <= 8'(PLL_IN_CYC - 1 + PLL_TOL));
   wire per_lost = (per_q > 8'(2 * PLL_IN_CYC));
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         per_q    <= 8'h00;
         pll_ok_q <= 1'b0;
      end
      else
      begin
         per_q    <= pll_in_tick ? 8'h00 : (per_q == 8'hFF ? per_q : per_q + 8'h01);
         if (!pll_want || per_lost)
            pll_ok_q <= 1'b0;
         else if (pll_in_tick)
            pll_ok_q <= per_ok;
      end
   end

   // One tick line per source code; one of them drives the system clock
   wire [7:0] src_ticks = {frc_ps_tick, frc16_tick, low_power_rc_osc_tick, sec_tick,
                           pll_sys_tick, pri_tick, pll_sys_tick, frc_tick};
   wire cur_tick = src_ticks[cur_src_q];
   wire tgt_tick = src_ticks[tgt_src_q];
   wire sys_tick = running && cur_tick;

   // Permissions and monitor
   wire switch_ok = !cfg_q.swmon[1];
   wire failsafe_clock_monitor_on   = (cfg_q.swmon == 2'b00);
   wire ext_src   = (cur_src_q == SRC_PRI) || (cur_src_q == SRC_PRIPLL)
                 || (cur_src_q == SRC_SEC);
   wire wd_done   = (wd_q >= 16'(FAILSAFE_CLOCK_MONITOR_CYC - 1));
   wire failsafe_clock_monitor_trip = (state_q == ST_RUN) && failsafe_clock_monitor_on && ext_src && wd_done;

   // Register decode
   wire wr_src   = bus.wr && (bus.addr == REG_SRC);
   wire wr_div   = bus.wr && (bus.addr == REG_DIV);
   wire clr_fail = bus.wr && (bus.addr == REG_STAT) && bus.wdata[STAT_FAIL];
   wire [15:0] stat_word = {3'h0, failsafe_clock_monitor_on, switch_ok, fail_q, pll_ok_q, pll_want,
                            cfg_q.out_fn, cfg_q.swmon, cfg_q.src, cfg_q.mode};
   wire [15:0] rd_mux = (bus.addr == REG_SRC)  ? {11'h000, state_q == ST_SWITCH,
                                                  1'b0, cur_src_q} :
                        (bus.addr == REG_DIV)  ? {9'h000, plldiv_q, 1'b0, rc_q} :
                        (bus.addr == REG_STAT) ? stat_word : 16'h0000;

   // Source state machine: capture at release, switch, fail-safe fallback
   wire watched = (state_q == ST_SWITCH) ? tgt_tick : cur_tick;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_q   <= ST_WAIT_CFG;
         cfg_q     <= '1;
         cur_src_q <= SRC_FAST_RC_WITH_POSTSCALER;
         tgt_src_q <= SRC_FAST_RC_WITH_POSTSCALER;
         wd_q      <= 16'h0000;
      end
      else
      begin
         wd_q <= (watched || failsafe_clock_monitor_trip) ? 16'h0000 : (wd_done ? wd_q : wd_q + 16'h0001);
         case (state_q)
            ST_WAIT_CFG:
            begin
               cfg_q     <= oss_cfg_unpack(cfg_word2);
               cur_src_q <= cfg_word2[CFG_SRC_LSB +: 3];
               state_q   <= ST_RUN;
            end
            ST_RUN:
            begin
               if (failsafe_clock_monitor_trip)
                  cur_src_q <= SRC_FRC;
               else if (wr_src && switch_ok)
               begin
                  tgt_src_q <= bus.wdata[2:0];
                  state_q   <= ST_SWITCH;
                  wd_q      <= 16'h0000;
               end
            end
            ST_SWITCH:
            begin
               if (tgt_tick)
               begin
                  cur_src_q <= tgt_src_q;
                  state_q   <= ST_RUN;
               end
               else if (wd_done)
                  state_q <= ST_RUN;
            end
            default:
               state_q <= ST_WAIT_CFG;
         endcase
      end
   end

   // Software registers and sticky failure flag; a trip beats a clear
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         rc_q     <= RC_RST;
         plldiv_q <= PLLDIV_RST;
         fail_q   <= 1'b0;
         rdata_q  <= 16'h0000;
      end
      else
      begin
         if (wr_div)
         begin
            rc_q     <= bus.wdata[2:0];
            plldiv_q <= bus.wdata[DIV_PLL_LSB +: 3];
         end
         fail_q  <= failsafe_clock_monitor_trip || (fail_q && !clr_fail);
         rdata_q <= bus.rd ? rd_mux : 16'h0000;
      end
   end

   // Instruction clock and oscillator output pin
   wire out_mode = (cfg_q.mode == MODE_EC) || (cfg_q.mode == MODE_OFF);
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         instr_q <= 1'b0;
         oe_n_q  <= 1'b1;
      end
      else
      begin
         if (sys_tick)
            instr_q <= !instr_q;
         oe_n_q <= !(running && cfg_q.out_fn && out_mode);
      end
   end

   // Outputs
   assign sys_clk_en       = sys_tick;
   assign instr_clk_en     = sys_tick && instr_q;
   assign instr_clk        = instr_q;
   assign usb_clk_en       = usb_tick && pll_want && pll_ok_q;
   assign gfx_clk_en       = pll_want && pll_ok_q;
   assign pll_active       = pll_want;
   assign failsafe_clock_monitor_fail        = fail_q;
   assign rdata            = rdata_q;
   assign osc_out_pin_o    = instr_q;
   assign osc_out_pin_oe_n = oe_n_q;

   // Helper: system ticks since the last instruction tick
   logic [1:0] sc_q;
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         sc_q <= 2'h0;
      else if (instr_clk_en)
         sc_q <= 2'h0;
      else if (sys_clk_en && sc_q != 2'h3)
         sc_q <= sc_q + 2'h1;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   AST_INSTR_DIV2: assert property (
      instr_clk_en |-> sys_clk_en && sc_q == 2'h1)
      else $error("instruction tick not every second system tick");
   AST_FRC_RATE: assert property (
      frc_tick |=> !frc_tick [*4] ##1 frc_tick)
      else $error("fast RC tick period is not five cycles");
   AST_CFG_CAPTURE: assert property (
      $past(state_q) == ST_WAIT_CFG && state_q == ST_RUN
      |-> cur_src_q == $past(cfg_word2[10:8]) && cfg_q.mode == $past(cfg_word2[1:0]))
      else $error("configuration not captured at release");
   AST_DEFAULT_SRC: assert property (
      running && cur_src_q == SRC_FAST_RC_WITH_POSTSCALER |-> sys_clk_en == frc_ps_tick)
      else $error("postscaled fast RC not on system clock");
   AST_NO_SWITCH: assert property (
      state_q == ST_RUN && cfg_q.swmon[1] |=> state_q != ST_SWITCH)
      else $error("switch started while forbidden");
   AST_FAILSAFE_CLOCK_MONITOR_GATE: assert property (
      $rose(fail_q) |-> cfg_q.swmon == 2'b00 && cur_src_q == SRC_FRC)
      else $error("monitor tripped while disabled");
   AST_FRC16_SRC: assert property (
      running && cur_src_q == SRC_FRC16 |-> sys_clk_en == frc16_tick)
      else $error("fast RC / 16 not on system clock");
   AST_PRI_SRC: assert property (
      running && cur_src_q == SRC_PRI |-> sys_clk_en == pri_tick)
      else $error("primary oscillator not on system clock");
   AST_FRC_SRC: assert property (
      running && cur_src_q == SRC_FRC |-> sys_clk_en == frc_tick)
      else $error("fast RC not on system clock");
   AST_PLL_GATE: assert property (
      usb_clk_en || gfx_clk_en |-> pll_active && pll_ok_q)
      else $error("PLL branch running without lock");
   AST_USB_HALF: assert property (
      usb_clk_en |=> !usb_clk_en)
      else $error("USB tick faster than half PLL rate");
   AST_HOLD_SRC: assert property (
      $past(state_q) == ST_RUN && $changed(cur_src_q) |-> fail_q && cur_src_q == SRC_FRC)
      else $error("source changed without switch or failure");
   AST_OSC_OUT: assert property (
      !osc_out_pin_oe_n |-> cfg_q.out_fn)
      else $error("output pin driven without function bit");

   COV_SWITCH: cover property (state_q == ST_SWITCH ##1 state_q == ST_RUN);
   COV_FAILSAFE_CLOCK_MONITOR: cover property ($rose(fail_q));
   COV_PLL_LOCK: cover property ($rose(pll_ok_q));

endmodule

// ===== src/oss_pkg.sv
// Oscillator source select: shared constants, field layouts and carriers.
// Assumes a single 40 MHz clock; every slower rate is a one-cycle tick.
package oss_pkg;

   // Clock rates and derived tick counts
   localparam int unsigned CLK_HZ     = 40_000_000;
   localparam int unsigned FRC_HZ     = 8_000_000;
   localparam int unsigned FRC_CYC    = CLK_HZ / FRC_HZ;
   localparam int unsigned PLL_IN_HZ  = 4_000_000;
   localparam int unsigned PLL_IN_CYC = CLK_HZ / PLL_IN_HZ;
   localparam int unsigned PLL_TOL    = 1;

   // Divider width and fixed divide values
   localparam int unsigned   DIV_W     = 16;
   localparam logic [15:0]   FRC_DIV   = 16'(FRC_CYC);
   localparam logic [15:0]   FRC16_DIV = 16'h0010;
   localparam logic [15:0]   USB_DIV   = 16'h0002;
   localparam logic [15:0]   DIV_ONE   = 16'h0001;

   // Initial source field codes
   localparam logic [2:0] SRC_FRC    = 3'h0;
   localparam logic [2:0] SRC_FAST_RC_WITH_PLL = 3'h1;
   localparam logic [2:0] SRC_PRI    = 3'h2;
   localparam logic [2:0] SRC_PRIPLL = 3'h3;
   localparam logic [2:0] SRC_SEC    = 3'h4;
   localparam logic [2:0] SRC_LOW_POWER_RC_OSC   = 3'h5;
   localparam logic [2:0] SRC_FRC16  = 3'h6;
   localparam logic [2:0] SRC_FAST_RC_WITH_POSTSCALER = 3'h7;

   // Primary mode field codes
   localparam logic [1:0] MODE_EC  = 2'h0;
   localparam logic [1:0] MODE_XT  = 2'h1;
   localparam logic [1:0] MODE_HS  = 2'h2;
   localparam logic [1:0] MODE_OFF = 2'h3;

   // Configuration word 2 field positions
   localparam int unsigned CFG_MODE_LSB  = 0;
   localparam int unsigned CFG_OUTFN_BIT = 5;
   localparam int unsigned CFG_SWMON_LSB = 6;
   localparam int unsigned CFG_SRC_LSB   = 8;

   // Register offsets and reset values
   localparam logic [7:0] REG_SRC      = 8'h00;
   localparam logic [7:0] REG_DIV      = 8'h04;
   localparam logic [7:0] REG_STAT     = 8'h08;
   localparam logic [2:0] RC_RST       = 3'h1;
   localparam logic [2:0] PLLDIV_RST   = 3'h1;
   localparam int unsigned DIV_PLL_LSB = 4;
   localparam int unsigned STAT_FAIL   = 10;

   // Latched configuration
   typedef struct packed {
      logic       out_fn;
      logic [1:0] swmon;
      logic [2:0] src;
      logic [1:0] mode;
   } oss_cfg_s;

   // Register port request
   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } oss_bus_s;

   // PLL input divider code to divide value
   function automatic logic [15:0] oss_pll_div(input logic [2:0] code);
      case (code)
         3'h7:    oss_pll_div = 16'h000C;
         3'h6:    oss_pll_div = 16'h0008;
         3'h5:    oss_pll_div = 16'h0006;
         3'h4:    oss_pll_div = 16'h0005;
         3'h3:    oss_pll_div = 16'h0004;
         3'h2:    oss_pll_div = 16'h0003;
         3'h1:    oss_pll_div = 16'h0002;
         default: oss_pll_div = 16'h0001;
      endcase
   endfunction

   // Unpack configuration word 2
   function automatic oss_cfg_s oss_cfg_unpack(input logic [15:0] w);
      oss_cfg_s c;
      c.mode   = w[CFG_MODE_LSB +: 2];
      c.out_fn = w[CFG_OUTFN_BIT];
      c.swmon  = w[CFG_SWMON_LSB +: 2];
      c.src    = w[CFG_SRC_LSB +: 3];
      oss_cfg_unpack = c;
   endfunction

endpackage

// ===== src/oss_tick_div.sv
// Tick divider: passes one of every div input ticks.
// Assumes tick_in is a one-cycle enable on clk; div of 0 acts as 1.
`timescale 1ns/10ps
module oss_tick_div
#(
   parameter int unsigned W = oss_pkg::DIV_W
)
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         sys_rst,
   // Tick stream
   input  wire logic         tick_in,
   input  wire logic [W-1:0] div,
   output logic              tick_out
);
   import oss_pkg::*;

   localparam logic [W-1:0] ONE = W'(1);

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic         last;

   // Last count reached; a shrunken divide value ends the count at once
   assign last     = (div <= ONE) || (cnt_q >= div - ONE);
   assign tick_out = tick_in && last;
   assign cnt_d    = !tick_in ? cnt_q : (last ? '0 : cnt_q + ONE);

   // Input tick counter
   always_ff @(posedge clk)
   begin
      if (sys_rst)
         cnt_q <= '0;
      else
         cnt_q <= cnt_d;
   end

endmodule

// ===== test/oss_clock_select_test.sv
// Self-checking bench for the oscillator source select block.
// Assumes the block's package and modules are compiled first; the bench
// drives every port itself and reads registers through the plain port.
`timescale 1ns/10ps
module oss_clock_select_test;
   import oss_pkg::*;

   // Design ports
   logic          clk;
   logic          sys_rst;
   logic [15:0]   cfg_word2;
   logic          pri_osc_pin;
   logic          sec_osc_pin;
   oss_bus_s      bus;
   logic [15:0]   rdata;
   logic          sys_clk_en;
   logic          instr_clk_en;
   logic          instr_clk;
   logic          usb_clk_en;
   logic          gfx_clk_en;
   logic          pll_active;
   logic          failsafe_clock_monitor_fail;
   logic          osc_out_pin_o;
   logic          osc_out_pin_oe_n;
   // Bench state
   int            fail_count;
   int            n_compared;
   logic [15:0]   exp_q[$];
   logic          rd_d;
   logic          pri_run;
   logic          sec_run;
   logic [2:0]    osc_cnt;
   logic [15:0]   lfsr;
   logic [15:0]   rnd;
   int            i;
   int            n_tog;
   int            n_ins;
   logic          prev_o;
   logic          prev_i;

   // Fast low-power source keeps the run brief; the monitor window must
   // exceed the slowest watched period (fast RC / 16, 80 cycles)
   oss_clock_select #(.LOW_POWER_RC_OSC_DIV(8), .PLL_SYS_DIV(3), .FAILSAFE_CLOCK_MONITOR_CYC(128)) uut
   (
      .clk              (clk),
      .sys_rst          (sys_rst),
      .cfg_word2        (cfg_word2),
      .pri_osc_pin      (pri_osc_pin),
      .sec_osc_pin      (sec_osc_pin),
      .bus              (bus),
      .rdata            (rdata),
      .sys_clk_en       (sys_clk_en),
      .instr_clk_en     (instr_clk_en),
      .instr_clk        (instr_clk),
      .usb_clk_en       (usb_clk_en),
      .gfx_clk_en       (gfx_clk_en),
      .pll_active       (pll_active),
      .failsafe_clock_monitor_fail        (failsafe_clock_monitor_fail),
      .osc_out_pin_o    (osc_out_pin_o),
      .osc_out_pin_oe_n (osc_out_pin_oe_n)
   );

   // 40 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // Oscillator pins give one rising edge every eight cycles while enabled
   always @(posedge clk)
   begin
      osc_cnt <= osc_cnt + 3'h1;
      pri_osc_pin <= pri_run & osc_cnt[2];
      sec_osc_pin <= sec_run & osc_cnt[2];
   end

   // Read data stands in the cycle after the strobe; compare with oldest note
   always @(posedge clk)
   begin
      rd_d <= bus.rd;
      if (rd_d === 1'b1)
      begin
         if (exp_q.size() == 0)
            check("read queue", 16'h0001, 16'h0000);
         else
            check("rdata", exp_q.pop_front(), rdata);
      end
   end

   // Compare and count
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      n_compared++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
         fail_count++;
      end
   endtask

   // Verdict and end of run
   task automatic stop_test();
      if (fail_count == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Register port cycles; the next call or idle releases the strobe
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
   endtask

   task automatic idle();
      bus <= '0;
      @(posedge clk);
      @(posedge clk);
   endtask

   // Reset for five cycles with a new configuration word
   task automatic do_reset(input logic [15:0] w);
      sys_rst <= 1'b1;
      cfg_word2 <= w;
      repeat (5) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   function automatic logic pick(input int sel);
      case (sel)
         0:       pick = sys_clk_en;
         1:       pick = instr_clk_en;
         default: pick = usb_clk_en;
      endcase
   endfunction

   // Cycles between two pulses of the chosen enable, bounded
   task automatic period(input int sel, output int n);
      int k;
      for (k = 0; k < 3000 && pick(sel) !== 1'b1; k++)
         @(posedge clk);
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pick(sel) !== 1'b1 && n < 3000);
      if (n >= 3000)
      begin
         check("pulse wait", 16'h0001, 16'h0000);
         stop_test();
      end
   endtask

   // Allows a few settling periods after a switch before judging
   task automatic expect_per(input int sel, input int exp, input string what);
      int n;
      int k;
      period(sel, n);
      for (k = 0; k < 16 && n != exp; k++)
         period(sel, n);
      check(what, 16'(exp), 16'(n));
   endtask

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Main sequence
   initial
   begin
      fail_count = 0;
      n_compared = 0;
      sys_rst = 1'b1;
      cfg_word2 = 16'hFFFF;
      pri_osc_pin = 1'b0;
      sec_osc_pin = 1'b0;
      bus = '0;
      rd_d = 1'b0;
      pri_run = 1'b0;
      sec_run = 1'b0;
      osc_cnt = 3'h0;
      lfsr = 16'h14AE;
      // Unprogrammed word: fast RC with postscaler, no switching
      do_reset(16'hFFFF);
      check("oe_n", 16'h0000, 16'(osc_out_pin_oe_n));
      check("gfx_clk_en", 16'h0000, 16'(gfx_clk_en));
      rd(REG_STAT, 16'h00FF);
      rd(REG_SRC, 16'h0007);
      rd(REG_DIV, 16'h0011);
      rd(8'h0C, 16'h0000);
      wr(REG_SRC, 16'h0000);
      rd(REG_SRC, 16'h0007);
      idle();
      expect_per(0, 10, "sys period");
      expect_per(1, 20, "instr period");
      for (i = 0; i < 3; i++)
      begin
         lfsr = lfsr_next(lfsr);
         rnd = lfsr & 16'h0077;
         wr(REG_DIV, rnd);
         rd(REG_DIV, rnd);
         idle();
         expect_per(0, 5 << rnd[2:0], "postscaled period");
      end
      // Fast RC, switching and monitor permitted
      do_reset(16'h0003);
      check("oe_n", 16'h0001, 16'(osc_out_pin_oe_n));
      rd(REG_STAT, 16'h1803);
      rd(REG_SRC, 16'h0000);
      idle();
      expect_per(0, 5, "frc period");
      // Fast RC at 8 MHz, PLL input divided by two gives the 4 MHz lock rate
      wr(REG_DIV, 16'h0010);
      wr(REG_SRC, 16'h0001);
      idle();
      for (i = 0; i < 500 && gfx_clk_en !== 1'b1; i++)
         @(posedge clk);
      check("gfx_clk_en", 16'h0001, 16'(gfx_clk_en));
      if (i >= 500)
         stop_test();
      check("pll_active", 16'h0001, 16'(pll_active));
      expect_per(0, 3, "pll sys period");
      expect_per(2, 2, "usb period");
      wr(REG_SRC, 16'h0005);
      idle();
      expect_per(0, 8, "low_power_rc_osc period");
      check("pll_active", 16'h0000, 16'(pll_active));
      wr(REG_SRC, 16'h0006);
      idle();
      expect_per(0, 80, "frc16 period");
      sec_run <= 1'b1;
      wr(REG_SRC, 16'h0004);
      idle();
      expect_per(0, 8, "sec period");
      check("failsafe_clock_monitor_fail", 16'h0000, 16'(failsafe_clock_monitor_fail));
      // Secondary stops: the monitor falls back to fast RC
      sec_run <= 1'b0;
      for (i = 0; i < 300 && failsafe_clock_monitor_fail !== 1'b1; i++)
         @(posedge clk);
      check("failsafe_clock_monitor_fail", 16'h0001, 16'(failsafe_clock_monitor_fail));
      if (i >= 300)
         stop_test();
      rd(REG_SRC, 16'h0000);
      wr(REG_STAT, 16'h0400);
      idle();
      check("failsafe_clock_monitor_fail", 16'h0000, 16'(failsafe_clock_monitor_fail));
      // External clock on the primary pin, pin carries instruction clock
      pri_run <= 1'b1;
      do_reset(16'h0220);
      rd(REG_SRC, 16'h0002);
      idle();
      check("oe_n", 16'h0000, 16'(osc_out_pin_oe_n));
      expect_per(0, 8, "primary period");
      expect_per(1, 16, "instr period");
      // Eight-cycle system ticks toggle the instruction clock 8 times in 64
      n_tog = 0;
      n_ins = 0;
      for (i = 0; i < 64; i++)
      begin
         prev_o = osc_out_pin_o;
         prev_i = instr_clk;
         @(posedge clk);
         n_tog += (osc_out_pin_o !== prev_o) ? 1 : 0;
         n_ins += (instr_clk !== prev_i) ? 1 : 0;
      end
      check("instr_clk toggles", 16'h0008, 16'(n_ins));
      check("osc_out_pin_o toggles", 16'h0008, 16'(n_tog));
      stop_test();
   end
endmodule
